// File: hdl/asrc_host.sv
// Purpose: host controller driving an asynchronous 16-bit static ram
// Assumes: memory pins sampled synchronously; one request at a time
// Notes:   address always changes with chip select high, writes are select-controlled
// Notes on behaviour
// - address changes only with select high
// - write strobe held high through every read
// - read drives select and output gate low
// - address valid before select falls for reads
// - never drive data while memory may drive
// - setup before write start, recovery before address change
// - deselect before retention, read-cycle wait after exit
`timescale 1ns/1ps
`include "asrc_params.svh"
`default_nettype none
module asrc_host #(
    parameter int READ_CYC  = `ASRC_READ_CYCLE_CYC,
    parameter int WRITE_CYC = `ASRC_WRITE_PULSE_CYC,
    parameter int TURN_CYC  = `ASRC_TURN_CYC
) (
    // clock and reset
    input  wire logic                     clk_in,
    input  wire logic                     rstn_in,
    // user request
    input  wire logic                     req_valid_in,
    input  wire asrc_pkg::asrc_req_s      req_in,
    output logic                          req_ready_out,
    // user answer
    output logic                          rsp_valid_out,
    output logic [`ASRC_DATA_W-1:0]       rsp_rdata_out,
    // retention control
    input  wire logic                     retain_in,
    output logic                          retained_out,
    // memory pins
    output logic [`ASRC_ADDR_W-1:0]       mem_addr_out,
    output asrc_pkg::asrc_strobe_s        mem_strobe_out,
    input  wire logic [`ASRC_DATA_W-1:0]  mem_dq_in,
    output logic [`ASRC_DATA_W-1:0]       mem_dq_out,
    output logic [1:0]                    mem_dq_oe_out
);
    // counts must fit the 8-bit phase timer
    if (READ_CYC < 1 || READ_CYC > 255 || WRITE_CYC < 1 || WRITE_CYC > 255 ||
        TURN_CYC < 1 || TURN_CYC > 255) begin : g_bad_timing
        $error("asrc_host: timing counts out of range");
    end

    ////////////////////////////////////////////////////////////////////////
    asrc_pkg::asrc_state_e state_r, state_nxt;
    asrc_pkg::asrc_req_s   cur_r, cur_nxt;
    asrc_pkg::asrc_strobe_s strb_r, strb_nxt;
    logic [`ASRC_DATA_W-1:0] rdata_r, rdata_nxt;
    logic [1:0]              oe_r, oe_nxt;
    logic                    rsp_r, rsp_nxt;
    logic                    ret_r, ret_nxt;
    logic                    load;
    logic [`ASRC_CNT_W-1:0]  load_val;
    logic                    done;

    asrc_timer #(.CNT_W(`ASRC_CNT_W)) u_timer (
        .clk_in   (clk_in),
        .rstn_in  (rstn_in),
        .load_in  (load),
        .value_in (load_val),
        .done_out (done)
    );

    localparam asrc_pkg::asrc_strobe_s IDLE_STRB = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1};

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        state_nxt = state_r;
        cur_nxt   = cur_r;
        strb_nxt  = strb_r;
        rdata_nxt = rdata_r;
        oe_nxt    = oe_r;
        rsp_nxt   = 1'b0;
        ret_nxt   = ret_r;
        load      = 1'b0;
        load_val  = '0;
        case (state_r)
            asrc_pkg::ASRC_IDLE: begin
                strb_nxt = IDLE_STRB;
                oe_nxt   = 2'b00;
                if (retain_in) begin
                    // already deselected, no delay needed before retention
                    ret_nxt   = 1'b1;
                    state_nxt = asrc_pkg::ASRC_RETAIN;
                end else if (req_valid_in) begin
                    // new address presented while select is still high
                    cur_nxt   = req_in;
                    load      = 1'b1;
                    load_val  = `ASRC_CNT_W'(`ASRC_SETUP_CYC);
                    state_nxt = asrc_pkg::ASRC_SETUP;
                    if (req_in.write) begin
                        // strobe falls ahead of select so the memory stays quiet
                        strb_nxt.write_n = 1'b0;
                    end
                end
            end
            asrc_pkg::ASRC_SETUP: begin
                if (done) begin
                    // select opens the cycle; byte enables pick lanes
                    strb_nxt.chip_sel_n         = 1'b0;
                    strb_nxt.low_byte_enable_n  = ~cur_r.byte_en[0];
                    strb_nxt.high_byte_enable_n = ~cur_r.byte_en[1];
                    if (cur_r.write) begin
                        // only drive after the strobe lowered, output gate stays high
                        oe_nxt   = cur_r.byte_en;
                        load_val = `ASRC_CNT_W'(WRITE_CYC);
                    end else begin
                        strb_nxt.write_n    = 1'b1;
                        strb_nxt.out_gate_n = 1'b0;
                        load_val = `ASRC_CNT_W'(READ_CYC);
                    end
                    load      = 1'b1;
                    state_nxt = asrc_pkg::ASRC_STROBE;
                end
            end
            asrc_pkg::ASRC_STROBE: begin
                if (done) begin
                    if (!cur_r.write) begin
                        // keep only enabled lanes of the returned word
                        rdata_nxt = {cur_r.byte_en[1] ? mem_dq_in[15:8] : 8'h00,
                                     cur_r.byte_en[0] ? mem_dq_in[7:0]  : 8'h00};
                    end
                    // select rises first: write ends, address held through recovery
                    strb_nxt.chip_sel_n = 1'b1;
                    strb_nxt.out_gate_n = 1'b1;
                    load      = 1'b1;
                    load_val  = `ASRC_CNT_W'(`ASRC_RECOVERY_CYC);
                    state_nxt = asrc_pkg::ASRC_HOLD;
                end
            end
            asrc_pkg::ASRC_HOLD: begin
                if (done) begin
                    strb_nxt  = IDLE_STRB;
                    oe_nxt    = 2'b00;
                    rsp_nxt   = 1'b1;
                    load      = 1'b1;
                    load_val  = `ASRC_CNT_W'(TURN_CYC);
                    state_nxt = asrc_pkg::ASRC_TURN;
                end
            end
            asrc_pkg::ASRC_TURN: begin
                // bus turnaround so the memory's outputs are off before we drive
                if (done) begin
                    state_nxt = asrc_pkg::ASRC_IDLE;
                end
            end
            asrc_pkg::ASRC_RETAIN: begin
                strb_nxt = IDLE_STRB;
                if (!retain_in) begin
                    ret_nxt   = 1'b0;
                    load      = 1'b1;
                    load_val  = `ASRC_CNT_W'(READ_CYC);
                    state_nxt = asrc_pkg::ASRC_WAKE;
                end
            end
            asrc_pkg::ASRC_WAKE: begin
                if (done) begin
                    state_nxt = asrc_pkg::ASRC_IDLE;
                end
            end
            default: begin
                state_nxt = asrc_pkg::ASRC_IDLE;
                strb_nxt  = IDLE_STRB;
                oe_nxt    = 2'b00;
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_r <= asrc_pkg::ASRC_IDLE;
            cur_r   <= '0;
            strb_r  <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
            rdata_r <= 16'h0000;
            oe_r    <= 2'b00;
            rsp_r   <= 1'b0;
            ret_r   <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cur_r   <= cur_nxt;
            strb_r  <= strb_nxt;
            rdata_r <= rdata_nxt;
            oe_r    <= oe_nxt;
            rsp_r   <= rsp_nxt;
            ret_r   <= ret_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign req_ready_out  = (state_r == asrc_pkg::ASRC_IDLE) && !retain_in;
    assign rsp_valid_out  = rsp_r;
    assign rsp_rdata_out  = rdata_r;
    assign retained_out   = ret_r;
    assign mem_addr_out   = cur_r.addr;
    assign mem_strobe_out = strb_r;
    assign mem_dq_out     = cur_r.wdata;
    assign mem_dq_oe_out  = oe_r;
endmodule : asrc_host
`default_nettype wire

// File: hdl/asrc_timer.sv
// Purpose: down counter that times each phase of a memory cycle
// Assumes: load and count never asserted together with a zero load value
// Notes:   done is high while the count is zero
`timescale 1ns/1ps
`default_nettype none
module asrc_timer #(
    parameter int CNT_W = 8
) (
    // clock and reset
    input  wire logic             clk_in,
    input  wire logic             rstn_in,
    // control
    input  wire logic             load_in,
    input  wire logic [CNT_W-1:0] value_in,
    // status
    output logic                  done_out
);
    if (CNT_W < 2) begin : g_bad_width
        $error("asrc_timer: CNT_W too small");
    end

    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;

    always_comb begin
        cnt_nxt = cnt_r;
        if (load_in) begin
            cnt_nxt = value_in;
        end else if (cnt_r != '0) begin
            cnt_nxt = cnt_r - {{(CNT_W-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    assign done_out = (cnt_r == '0);
endmodule : asrc_timer
`default_nettype wire

// File: inc/asrc_params.svh
// Purpose: timing counts and widths for the asynchronous sram host controller
// Assumes: 125 MHz clock, 8 ns period
// Notes:   times in ns as printed; cycle counts derived by rounding up
`ifndef ASRC_PARAMS_SVH
`define ASRC_PARAMS_SVH

`define ASRC_CLK_PERIOD_NS      8
`define ASRC_ADDR_W             17
`define ASRC_DATA_W             16
// least times, ns
`define ASRC_READ_CYCLE_NS      55
`define ASRC_WRITE_PULSE_NS     45
`define ASRC_WRITE_ADDR_SETUP_NS 0
`define ASRC_WRITE_RECOVERY_NS  0
`define ASRC_OUT_DISABLE_NS     25
`define ASRC_DESEL_TO_RET_NS    0
// ceiling division, at least one cycle
`define ASRC_CYC(ns) ((((ns) + `ASRC_CLK_PERIOD_NS - 1) / `ASRC_CLK_PERIOD_NS) < 1 ? 1 : \
                      (((ns) + `ASRC_CLK_PERIOD_NS - 1) / `ASRC_CLK_PERIOD_NS))
`define ASRC_READ_CYCLE_CYC     `ASRC_CYC(`ASRC_READ_CYCLE_NS)
`define ASRC_WRITE_PULSE_CYC    `ASRC_CYC(`ASRC_WRITE_PULSE_NS)
`define ASRC_SETUP_CYC          `ASRC_CYC(`ASRC_WRITE_ADDR_SETUP_NS)
`define ASRC_RECOVERY_CYC       `ASRC_CYC(`ASRC_WRITE_RECOVERY_NS)
`define ASRC_TURN_CYC           `ASRC_CYC(`ASRC_OUT_DISABLE_NS)
`define ASRC_RET_RECOVERY_CYC   `ASRC_READ_CYCLE_CYC
`define ASRC_CNT_W              8

`endif

// File: inc/asrc_pkg.sv
// Purpose: shared types for the asynchronous sram host controller
// Assumes: nothing
// Notes:   strobes are active low on the pins
package asrc_pkg;

    typedef struct packed {
        logic        write;
        logic [1:0]  byte_en;
        logic [16:0] addr;
        logic [15:0] wdata;
    } asrc_req_s;

    typedef struct packed {
        logic       chip_sel_n;
        logic       write_n;
        logic       out_gate_n;
        logic       low_byte_enable_n;
        logic       high_byte_enable_n;
    } asrc_strobe_s;

    typedef enum logic [2:0] {
        ASRC_IDLE   = 3'b000,
        ASRC_SETUP  = 3'b001,
        ASRC_STROBE = 3'b011,
        ASRC_HOLD   = 3'b010,
        ASRC_TURN   = 3'b110,
        ASRC_RETAIN = 3'b111,
        ASRC_WAKE   = 3'b101
    } asrc_state_e;

endpackage : asrc_pkg

// File: sim/asrc_host_asserts.sv
// Purpose: pin protocol checks for the sram host
// Assumes: latencies as the host state machine gives them
// Notes:   bound into every host instance
`timescale 1ns/1ps
`default_nettype none
module asrc_host_asserts #(
    parameter int READ_CYC  = 7,
    parameter int WRITE_CYC = 6,
    parameter int TURN_CYC  = 4
) (
    // clock, reset and user side
    input wire logic                   clk_in,
    input wire logic                   rstn_in,
    input wire logic                   req_valid_in,
    input wire asrc_pkg::asrc_req_s    req_in,
    input wire logic                   req_ready_out,
    input wire logic                   rsp_valid_out,
    input wire logic                   retained_out,
    // memory pins
    input wire logic [16:0]            mem_addr_out,
    input wire asrc_pkg::asrc_strobe_s mem_strobe_out,
    input wire logic [1:0]             mem_dq_oe_out
);
    // a phase loaded with n lasts n+1 cycles; setup and recovery are 1 each
    localparam int RD_LAT = READ_CYC + 6;
    localparam int WR_LAT = WRITE_CYC + 6;
    wire cs_n = mem_strobe_out.chip_sel_n;
    wire we_n = mem_strobe_out.write_n;
    wire oe_n = mem_strobe_out.out_gate_n;
    wire [1:0] be_n = {mem_strobe_out.high_byte_enable_n, mem_strobe_out.low_byte_enable_n};
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rstn_in);
    sequence s_rd_take;
        req_valid_in && req_ready_out && !req_in.write;
    endsequence
    sequence s_wr_take;
        req_valid_in && req_ready_out && req_in.write;
    endsequence
    chk_addr_move: assert property ($changed(mem_addr_out) |-> cs_n && $past(cs_n))
        else $error("address moved while selected");
    chk_read_we: assert property (!cs_n && !oe_n |-> we_n)
        else $error("write strobe low in a read");
    chk_read_pins: assert property (s_rd_take |-> ##3 !cs_n && !oe_n && be_n == ~$past(req_in.byte_en, 3))
        else $error("read strobes wrong");
    chk_read_done: assert property (s_rd_take |-> ##RD_LAT rsp_valid_out)
        else $error("read answer late");
    chk_addr_setup: assert property ($fell(cs_n) |-> $stable(mem_addr_out))
        else $error("address not settled at select");
    chk_no_fight: assert property (|mem_dq_oe_out |-> oe_n && !we_n)
        else $error("host drives while ram may drive");
    chk_we_first: assert property ($fell(cs_n) && !we_n |-> !$past(we_n))
        else $error("select fell before write strobe");
    chk_write_lanes: assert property (s_wr_take |-> ##3 !cs_n && !we_n && mem_dq_oe_out == $past(req_in.byte_en, 3))
        else $error("write lanes wrong");
    chk_write_done: assert property (s_wr_take |-> ##WR_LAT rsp_valid_out && we_n)
        else $error("write answer late");
    chk_retain_desel: assert property (retained_out |-> cs_n && $past(cs_n))
        else $error("selected in retention");
    chk_wake_wait: assert property ($fell(retained_out) |-> !req_ready_out [*7])
        else $error("access too soon after retention");
endmodule : asrc_host_asserts
bind asrc_host asrc_host_asserts #(.READ_CYC(READ_CYC), .WRITE_CYC(WRITE_CYC), .TURN_CYC(TURN_CYC)) u_chk (
    .clk_in(clk_in), .rstn_in(rstn_in), .req_valid_in(req_valid_in), .req_in(req_in),
    .req_ready_out(req_ready_out), .rsp_valid_out(rsp_valid_out), .retained_out(retained_out),
    .mem_addr_out(mem_addr_out), .mem_strobe_out(mem_strobe_out), .mem_dq_oe_out(mem_dq_oe_out));
`default_nettype wire

// File: sim/asrc_sram_model.sv
// Purpose: behavioural 128K x 16 static ram facing the host pins
// Assumes: pins are registered by the host, so sampling on clk_in is safe
// Notes:   released lanes show a changing pattern, never the last value
`timescale 1ns/1ps
`default_nettype none
module asrc_sram_model (
    // pins from the host
    input  wire logic                   clk_in,
    input  wire logic [16:0]            addr_in,
    input  wire asrc_pkg::asrc_strobe_s strobe_in,
    input  wire logic [15:0]            dq_in,
    // data the ram drives
    output logic [15:0]                 dq_out
);
    logic [15:0] mem [0:131071];
    logic [15:0] junk_r = 16'hA5A5;
    logic        rd;
    // write strobe ignored unless selected, and it blocks the output
    assign rd = !strobe_in.chip_sel_n && !strobe_in.out_gate_n && strobe_in.write_n;
    assign dq_out[7:0]  = (rd && !strobe_in.low_byte_enable_n) ? mem[addr_in][7:0] : junk_r[7:0];
    assign dq_out[15:8] = (rd && !strobe_in.high_byte_enable_n) ? mem[addr_in][15:8] : junk_r[15:8];
    always_ff @(posedge clk_in) begin
        junk_r <= junk_r + 16'h5A5B;
        if (!strobe_in.chip_sel_n && !strobe_in.write_n) begin
            if (!strobe_in.low_byte_enable_n) mem[addr_in][7:0] <= dq_in[7:0];
            if (!strobe_in.high_byte_enable_n) mem[addr_in][15:8] <= dq_in[15:8];
        end
    end
endmodule : asrc_sram_model
`default_nettype wire

// File: sim/tb.sv
// Purpose: self-checking bench for the sram host
// Assumes: default latencies
// Notes:   the ram model answers on the shared data wire
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk_in, rstn_in, req_valid_in, retain_in, req_ready_out, rsp_valid_out, retained_out;
    asrc_pkg::asrc_req_s    req_in;
    asrc_pkg::asrc_strobe_s mem_strobe_out;
    logic [15:0] rsp_rdata_out, mem_dq_in, mem_dq_out, ram_dq;
    logic [16:0] mem_addr_out;
    logic [1:0]  mem_dq_oe_out;
    int          fail_count = 0;
    int          total_checks = 0;
    assign mem_dq_in = {mem_dq_oe_out[1] ? mem_dq_out[15:8] : ram_dq[15:8],
                        mem_dq_oe_out[0] ? mem_dq_out[7:0] : ram_dq[7:0]};
    asrc_host u_asrc_host (.clk_in(clk_in), .rstn_in(rstn_in), .req_valid_in(req_valid_in), .req_in(req_in),
        .req_ready_out(req_ready_out), .rsp_valid_out(rsp_valid_out), .rsp_rdata_out(rsp_rdata_out),
        .retain_in(retain_in), .retained_out(retained_out), .mem_addr_out(mem_addr_out),
        .mem_strobe_out(mem_strobe_out), .mem_dq_in(mem_dq_in), .mem_dq_out(mem_dq_out),
        .mem_dq_oe_out(mem_dq_oe_out));
    asrc_sram_model u_asrc_sram_model (.clk_in(clk_in), .addr_in(mem_addr_out), .strobe_in(mem_strobe_out),
        .dq_in(mem_dq_in), .dq_out(ram_dq));
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic xfer(input logic wr, input logic [1:0] be, input logic [16:0] a, input logic [15:0] d);
        int n;
        @(posedge clk_in);
        #1;
        req_in = '{write: wr, byte_en: be, addr: a, wdata: d};
        req_valid_in = 1'b1;
        for (n = 0; n < 200 && req_ready_out !== 1'b1; n++) @(negedge clk_in);
        @(posedge clk_in);
        #1;
        req_valid_in = 1'b0;
        for (n = 0; n < 40 && rsp_valid_out !== 1'b1; n++) @(negedge clk_in);
        chk("response", 16'h0001, {15'h0000, rsp_valid_out});
    endtask : xfer
    task automatic rd(input logic [1:0] be, input logic [16:0] a, input logic [15:0] exp);
        xfer(1'b0, be, a, 16'h0000);
        chk("read data", exp, rsp_rdata_out);
    endtask : rd
    task automatic s_words;
        xfer(1'b1, 2'h3, 17'h00000, 16'hA5C3);
        xfer(1'b1, 2'h3, 17'h1FFFF, 16'h1234);
        rd(2'h3, 17'h00000, 16'hA5C3);
        rd(2'h3, 17'h1FFFF, 16'h1234);
    endtask : s_words
    task automatic s_lanes;
        xfer(1'b1, 2'h1, 17'h00000, 16'h7E11);
        rd(2'h3, 17'h00000, 16'hA511);
        rd(2'h2, 17'h00000, 16'hA500);
        rd(2'h0, 17'h00000, 16'h0000);
    endtask : s_lanes
    task automatic s_retain;
        int n;
        @(posedge clk_in);
        #1;
        retain_in = 1'b1;
        // retention is honoured only once the turnaround of the last access is over
        for (n = 0; n < 20 && retained_out !== 1'b1; n++) @(negedge clk_in);
        chk("retained", 16'h0001, {15'h0000, retained_out});
        chk("ready in retention", 16'h0000, {15'h0000, req_ready_out});
        @(posedge clk_in);
        #1;
        retain_in = 1'b0;
        for (n = 0; n < 50 && req_ready_out !== 1'b1; n++) @(negedge clk_in);
        chk("wake wait", 16'h0001, {15'h0000, n >= 7});
        rd(2'h3, 17'h1FFFF, 16'h1234);
    endtask : s_retain
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : wrap_up
    initial begin
        clk_in = 1'b0;
        forever #4 clk_in = ~clk_in;
    end
    initial begin
        #100000;
        fail_count++;
        wrap_up();
    end
    initial begin
        rstn_in = 1'b0;
        req_valid_in = 1'b0;
        retain_in = 1'b0;
        req_in = '0;
        repeat (10) @(posedge clk_in);
        #1;
        rstn_in = 1'b1;
        s_words();
        s_lanes();
        s_retain();
        wrap_up();
    end
endmodule : tb
`default_nettype wire
